// *** tte_regs.vh ***
`ifndef TTE_REGS_VH
`define TTE_REGS_VH
// register byte offsets
`define TTE_OFF_CMD        8'h00
`define TTE_OFF_TS_PERIOD  8'h04
`define TTE_OFF_VEC_MAP    8'h08
`define TTE_OFF_BLK_FUNC   8'h0c
`define TTE_OFF_PARSE_CHR  8'h10
`define TTE_OFF_STATUS     8'h14
`define TTE_OFF_TS_COUNT   8'h18
`define TTE_OFF_PARSE_VAL  8'h1c
// command word fields
`define TTE_CMD_OP_HI      4
`define TTE_CMD_OP_LO      0
`define TTE_CMD_TERM_HI    6
`define TTE_CMD_TERM_LO    5
`define TTE_CMD_TERM_GIVEN 7
`define TTE_CMD_ARG        8
`define TTE_CMD_LINE_BP    9
// command opcodes
`define TTE_OP_ARM_VEC     5'h00
`define TTE_OP_ARM_CRC     5'h01
`define TTE_OP_ARM_TX      5'h02
`define TTE_OP_ARM_ERR     5'h03
`define TTE_OP_DATA_RADIX  5'h04
`define TTE_OP_PARAM_RADIX 5'h05
`define TTE_OP_SYS_ERR_EN  5'h06
`define TTE_OP_SYS_VEC_EN  5'h07
`define TTE_OP_THRESH      5'h08
`define TTE_OP_EOW_EN      5'h09
`define TTE_OP_TEST_MOD_BP 5'h0a
`define TTE_OP_TEST_MOD_EX 5'h0b
`define TTE_OP_TEST_TRM_BP 5'h0c
`define TTE_OP_TEST_TRM_EX 5'h0d
`define TTE_OP_SELF_TEST   5'h0e
`define TTE_OP_CLR_COMMERR 5'h0f
// status word fields
`define TTE_ST_DATA_HEX    0
`define TTE_ST_PARAM_HEX   1
`define TTE_ST_SYS_ERR_EN  2
`define TTE_ST_SYS_VEC_EN  3
`define TTE_ST_TERM_LO     4
`define TTE_ST_CMD_ERR     6
`define TTE_ST_THRESH_LO   7
`define TTE_ST_EOW_LO      10
`define TTE_ST_LOCK_LO     13
`define TTE_ST_TS_RUN      16
// field positions of vectors and table writes
`define TTE_VEC_FLAG_BIT   13
`define TTE_MAP_BLK_LO     16
`define TTE_BLKF_FN_LO     8
// constants and reset values
`define TTE_FN_SYSVEC      5'h0f
`define TTE_TS_PERIOD_MAX  15'h7fff
`define TTE_TS_PERIOD_RST  15'h0001
`define TTE_CHR_HASH       8'h23
`define TTE_CHR_PCT        8'h25
// timing
`define TTE_CLK_NS         10
`define TTE_BIT_NS         500
`define TTE_US_NS          1000
`define TTE_US_CYC         (`TTE_US_NS / `TTE_CLK_NS)
`define TTE_EARLY_CYC      ((3 * `TTE_BIT_NS) / `TTE_CLK_NS)
`define TTE_LATE_CYC       ((7 * `TTE_BIT_NS) / (2 * `TTE_CLK_NS))
`define TTE_EOW_CYC        ((5 * `TTE_BIT_NS) / (2 * `TTE_CLK_NS))
`define TTE_TRIG_NS        1000
`define TTE_TRIG_CYC       (`TTE_TRIG_NS / `TTE_CLK_NS)
`endif

// *** tte_mem.v ***
`timescale 1ns/1ps
// =============================================
// table memory, registered read
module tte_mem #(
  parameter AW = 9,
  parameter DW = 8
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_ff [0:(1<<AW)-1];

  // read during write of the same word returns the old contents
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_ff[raddr_i];
  end
endmodule // tte_mem

// *** tte_pulse.v ***
`timescale 1ns/1ps
// =============================================
// single active-low trigger pulse
module tte_pulse #(
  parameter WIDTH = 100
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire start_i,
  output reg  trig_n_o
);
  reg [15:0] cnt_ff;

  // starts during a pulse or its last cycle are absorbed, so pulses never merge
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff   <= 16'h0000;
      trig_n_o <= 1'b1;
    end else if (cnt_ff != 16'h0000) begin
      cnt_ff   <= cnt_ff - 16'h0001;
      trig_n_o <= 1'b0;
    end else if (start_i & trig_n_o) begin
      cnt_ff   <= WIDTH[15:0] - 16'h0001;
      trig_n_o <= 1'b0;
    end else begin
      trig_n_o <= 1'b1;
    end
  end
endmodule // tte_pulse

// *** tte_top.v ***
// Notes on behaviour
// - armed terminal pulses its external trigger on each vector with bit 13 set.
// - crc arming pulses only for bit-13 vectors right after a bad-crc wordstring.
// - terminal index 0..2 optional; omitted uses last given terminal.
// - data radix decimal or hex, hex after reset.
// - separate parameter radix, decimal or hex, hex after reset.
// - hash prefix forces hex, percent prefix forces decimal.
// - error events interrupt the controller only while error interrupt is enabled.
// - per terminal receive threshold select, high 1000 mV or low 700 mV.
// - executing function f interrupts the controller only while enabled.
// - timestamp period 1..7fff us; writing it clears and starts the count.
// - 256 instruction blocks with 5-bit function codes; host avoids live rewrites.
// - vector table maps vectors 0..1ff to a block executed per vector.
// - end-of-wordstring stamped vector 2.5 bit times after end, if enabled and its label vector has bit 13 set.
// - early vector 3 bit times, late vector 3.5 bit times after label.
// - test commands fire one negative pulse on the addressed trigger line.
// - self test tells the serial interface module to swap coupler electronics.
// - a fired comm-error trigger locks out its terminal's armed triggers until cleared; test commands still fire.
// - armed terminal pulses trigger when it begins to transmit.
`timescale 1ns/1ps
`include "tte_regs.vh"
module tte_top #(
  parameter NT       = 3,
  parameter TRIG_CYC = `TTE_TRIG_CYC
) (
  input  wire           clk_i,
  input  wire           rst_i,
  input  wire           wb_cyc_i,
  input  wire           wb_stb_i,
  input  wire           wb_we_i,
  input  wire [7:0]     wb_adr_i,
  input  wire [3:0]     wb_sel_i,
  input  wire [31:0]    wb_dat_i,
  output reg  [31:0]    wb_dat_o,
  output reg            wb_ack_o,
  input  wire           vec_stb_i,
  input  wire [1:0]     vec_term_i,
  input  wire [15:0]    vec_code_i,
  input  wire [NT-1:0]  crc_fail_i,
  input  wire [NT-1:0]  tx_start_i,
  input  wire [NT-1:0]  comm_err_i,
  input  wire           sys_err_event_i,
  input  wire [NT-1:0]  rx_label_i,
  input  wire [16*NT-1:0] rx_vec_i,
  input  wire [NT-1:0]  ws_end_i,
  output wire [NT-1:0]  trig_ext_n_o,
  output wire [NT-1:0]  trig_bp_n_o,
  output wire           mod_trig_ext_n_o,
  output wire           mod_trig_bp_n_o,
  output reg  [NT-1:0]  thresh_high_o,
  output reg  [NT-1:0]  self_test_o,
  output reg            sys_err_irq_o,
  output reg            sys_vec_irq_o,
  output reg            exec_stb_o,
  output reg  [7:0]     exec_block_o,
  output reg  [4:0]     exec_func_o,
  output wire [NT-1:0]  early_vec_o,
  output wire [NT-1:0]  late_vec_o,
  output reg            stamp_stb_o,
  output reg  [1:0]     stamp_term_o,
  output reg  [15:0]    stamp_vec_o,
  output reg  [31:0]    stamp_time_o,
  output reg            data_radix_hex_o
);
  // =============================================
  // bus decode
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr       = req & wb_we_i & (wb_sel_i == 4'hf);
  wire        wr_cmd   = wr & (wb_adr_i == `TTE_OFF_CMD);
  wire        wr_per   = wr & (wb_adr_i == `TTE_OFF_TS_PERIOD);
  wire        wr_map   = wr & (wb_adr_i == `TTE_OFF_VEC_MAP);
  wire        wr_blk   = wr & (wb_adr_i == `TTE_OFF_BLK_FUNC);
  wire        wr_chr   = wr & (wb_adr_i == `TTE_OFF_PARSE_CHR);
  wire        wr_st    = wr & (wb_adr_i == `TTE_OFF_STATUS);
  wire [4:0]  op       = wb_dat_i[`TTE_CMD_OP_HI:`TTE_CMD_OP_LO];
  wire [1:0]  t_given  = wb_dat_i[`TTE_CMD_TERM_HI:`TTE_CMD_TERM_LO];
  wire        has_t    = wb_dat_i[`TTE_CMD_TERM_GIVEN];
  wire        arg      = wb_dat_i[`TTE_CMD_ARG];
  wire        line_bp  = wb_dat_i[`TTE_CMD_LINE_BP];

  reg  [1:0]  cur_term_ff;
  reg         cmd_err_ff;
  wire [1:0]  term     = has_t ? t_given : cur_term_ff;
  wire        t_bad    = (term > 2'd2);
  wire        do_cmd   = wr_cmd & ~t_bad;
  wire [NT-1:0] t_sel  = do_cmd ? ({{(NT-1){1'b0}}, 1'b1} << term) : {NT{1'b0}};

  // =============================================
  // global and per-terminal settings
  reg         param_hex_ff;
  reg         sys_err_en_ff;
  reg         sys_vec_en_ff;
  reg [NT-1:0] eow_en_ff;
  reg [8*NT-1:0] arm_ff;
  reg [NT-1:0] lock_ff;
  reg [NT-1:0] test_ext;
  reg [NT-1:0] test_bp;
  reg [NT-1:0] clr_err;
  integer     i;

  always @* begin
    for (i = 0; i < NT; i = i + 1) begin
      test_ext[i] = t_sel[i] & (op == `TTE_OP_TEST_TRM_EX);
      test_bp[i]  = t_sel[i] & (op == `TTE_OP_TEST_TRM_BP);
      clr_err[i]  = t_sel[i] & (op == `TTE_OP_CLR_COMMERR);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cur_term_ff      <= 2'd0;
      cmd_err_ff       <= 1'b0;
      data_radix_hex_o <= 1'b1;
      param_hex_ff     <= 1'b1;
      sys_err_en_ff    <= 1'b0;
      sys_vec_en_ff    <= 1'b0;
      thresh_high_o    <= {NT{1'b0}};
      eow_en_ff        <= {NT{1'b0}};
      arm_ff           <= {(8*NT){1'b0}};
      self_test_o      <= {NT{1'b0}};
    end else begin
      self_test_o <= {NT{1'b0}};
      // a refused command sets the flag even while software clears it
      if (wr_cmd & t_bad) begin
        cmd_err_ff <= 1'b1;
      end else if (wr_st & wb_dat_i[`TTE_ST_CMD_ERR]) begin
        cmd_err_ff <= 1'b0;
      end
      if (do_cmd & has_t) begin
        cur_term_ff <= t_given;
      end
      if (do_cmd) begin
        case (op)
          `TTE_OP_DATA_RADIX:  data_radix_hex_o <= arg;
          `TTE_OP_PARAM_RADIX: param_hex_ff <= arg;
          `TTE_OP_SYS_ERR_EN:  sys_err_en_ff <= arg;
          `TTE_OP_SYS_VEC_EN:  sys_vec_en_ff <= arg;
          `TTE_OP_THRESH:      thresh_high_o[term] <= arg;
          `TTE_OP_EOW_EN:      eow_en_ff[term] <= arg;
          `TTE_OP_SELF_TEST:   self_test_o[term] <= 1'b1;
          `TTE_OP_ARM_VEC, `TTE_OP_ARM_CRC, `TTE_OP_ARM_TX, `TTE_OP_ARM_ERR: begin
            arm_ff[term*8 + line_bp*4 + op[1:0]] <= arg;
          end
          default: ;
        endcase
      end
    end
  end

  // =============================================
  // trigger qualification
  wire [NT-1:0] start_ext;
  wire [NT-1:0] start_bp;
  wire [NT-1:0] err_fire;
  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_trig
      wire       vhit = vec_stb_i & (vec_term_i == g) & vec_code_i[`TTE_VEC_FLAG_BIT];
      wire [3:0] ae   = arm_ff[g*8 +: 4];
      wire [3:0] ab   = arm_ff[g*8+4 +: 4];
      wire       e_ev = (ae[0] & vhit) | (ae[1] & vhit & crc_fail_i[g]) |
                        (ae[2] & tx_start_i[g]);
      wire       b_ev = (ab[0] & vhit) | (ab[1] & vhit & crc_fail_i[g]) |
                        (ab[2] & tx_start_i[g]);
      wire       e_er = ae[3] & comm_err_i[g] & ~lock_ff[g];
      wire       b_er = ab[3] & comm_err_i[g] & ~lock_ff[g];
      assign err_fire[g]  = e_er | b_er;
      assign start_ext[g] = ((e_ev & ~lock_ff[g]) | e_er) | test_ext[g];
      assign start_bp[g]  = ((b_ev & ~lock_ff[g]) | b_er) | test_bp[g];
      tte_pulse #(.WIDTH(TRIG_CYC)) u_ext (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (start_ext[g]),
        .trig_n_o (trig_ext_n_o[g])
      );
      tte_pulse #(.WIDTH(TRIG_CYC)) u_bp (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (start_bp[g]),
        .trig_n_o (trig_bp_n_o[g])
      );
    end
  endgenerate

  // lockout: a new error firing wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      lock_ff <= {NT{1'b0}};
    end else begin
      lock_ff <= err_fire | (lock_ff & ~clr_err);
    end
  end

  tte_pulse #(.WIDTH(TRIG_CYC)) u_mod_ext (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (do_cmd & (op == `TTE_OP_TEST_MOD_EX)),
    .trig_n_o (mod_trig_ext_n_o)
  );
  tte_pulse #(.WIDTH(TRIG_CYC)) u_mod_bp (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (do_cmd & (op == `TTE_OP_TEST_MOD_BP)),
    .trig_n_o (mod_trig_bp_n_o)
  );

  // =============================================
  // vector execution pipeline
  wire [7:0] map_blk;
  wire [4:0] blk_fn;
  reg        p1_ff;
  reg        p2_ff;
  reg [7:0]  p2_blk_ff;

  tte_mem #(.AW(9), .DW(8)) u_vec_map (
    .clk_i   (clk_i),
    .we_i    (wr_map),
    .waddr_i (wb_dat_i[8:0]),
    .wdata_i (wb_dat_i[`TTE_MAP_BLK_LO +: 8]),
    .raddr_i (vec_code_i[8:0]),
    .rdata_o (map_blk)
  );
  tte_mem #(.AW(8), .DW(5)) u_blk_fn (
    .clk_i   (clk_i),
    .we_i    (wr_blk),
    .waddr_i (wb_dat_i[7:0]),
    .wdata_i (wb_dat_i[`TTE_BLKF_FN_LO +: 5]),
    .raddr_i (map_blk),
    .rdata_o (blk_fn)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      p1_ff         <= 1'b0;
      p2_ff         <= 1'b0;
      p2_blk_ff     <= 8'h00;
      exec_stb_o    <= 1'b0;
      exec_block_o  <= 8'h00;
      exec_func_o   <= 5'h00;
      sys_vec_irq_o <= 1'b0;
      sys_err_irq_o <= 1'b0;
    end else begin
      p1_ff         <= vec_stb_i;
      p2_ff         <= p1_ff;
      p2_blk_ff     <= map_blk;
      exec_stb_o    <= p2_ff;
      if (p2_ff) begin
        exec_block_o <= p2_blk_ff;
        exec_func_o  <= blk_fn;
      end
      sys_vec_irq_o <= p2_ff & (blk_fn == `TTE_FN_SYSVEC) & sys_vec_en_ff;
      sys_err_irq_o <= sys_err_event_i & sys_err_en_ff;
    end
  end

  // =============================================
  // timestamp clock
  reg [14:0] period_ff;
  reg [14:0] per_cnt_ff;
  reg [6:0]  us_cnt_ff;
  reg [31:0] ts_ff;
  reg        ts_run_ff;
  wire       us_tick = (us_cnt_ff == `TTE_US_CYC - 1);
  wire [14:0] per_new = (wb_dat_i[14:0] == 15'h0000) ? `TTE_TS_PERIOD_RST : wb_dat_i[14:0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      period_ff  <= `TTE_TS_PERIOD_RST;
      per_cnt_ff <= 15'h0000;
      us_cnt_ff  <= 7'h00;
      ts_ff      <= 32'h0000_0000;
      ts_run_ff  <= 1'b0;
    end else if (wr_per) begin
      period_ff  <= per_new;
      per_cnt_ff <= 15'h0000;
      us_cnt_ff  <= 7'h00;
      ts_ff      <= 32'h0000_0000;
      ts_run_ff  <= 1'b1;
    end else if (ts_run_ff) begin
      us_cnt_ff <= us_tick ? 7'h00 : us_cnt_ff + 7'h01;
      if (us_tick) begin
        if (per_cnt_ff == period_ff - 15'h0001) begin
          per_cnt_ff <= 15'h0000;
          ts_ff      <= ts_ff + 32'h0000_0001;
        end else begin
          per_cnt_ff <= per_cnt_ff + 15'h0001;
        end
      end
    end
  end

  // =============================================
  // label and end-of-wordstring vector timing
  wire [NT-1:0] eow_fire;
  wire [16*NT-1:0] lbl_vec;
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_time
      reg [7:0]  lc_ff;
      reg [7:0]  wc_ff;
      reg        la_ff;
      reg        wa_ff;
      reg        early_ff;
      reg        late_ff;
      reg [15:0] v_ff;
      assign early_vec_o[g] = early_ff;
      assign late_vec_o[g]  = late_ff;
      assign lbl_vec[16*g +: 16] = v_ff;
      assign eow_fire[g] = wa_ff & (wc_ff == `TTE_EOW_CYC) & eow_en_ff[g] &
                           v_ff[`TTE_VEC_FLAG_BIT];
      always @(posedge clk_i) begin
        if (rst_i) begin
          lc_ff <= 8'h00; wc_ff <= 8'h00; la_ff <= 1'b0; wa_ff <= 1'b0;
          early_ff <= 1'b0; late_ff <= 1'b0; v_ff <= 16'h0000;
        end else begin
          early_ff <= la_ff & (lc_ff == `TTE_EARLY_CYC);
          late_ff  <= la_ff & (lc_ff == `TTE_LATE_CYC);
          if (rx_label_i[g]) begin
            la_ff <= 1'b1;
            lc_ff <= 8'h01;
            v_ff  <= rx_vec_i[16*g +: 16];
          end else if (la_ff) begin
            la_ff <= (lc_ff != `TTE_LATE_CYC);
            lc_ff <= lc_ff + 8'h01;
          end
          if (ws_end_i[g]) begin
            wa_ff <= 1'b1;
            wc_ff <= 8'h01;
          end else if (wa_ff) begin
            wa_ff <= (wc_ff != `TTE_EOW_CYC);
            wc_ff <= wc_ff + 8'h01;
          end
        end
      end
    end
  endgenerate

  // lowest terminal wins when end stamps coincide
  always @(posedge clk_i) begin
    if (rst_i) begin
      stamp_stb_o  <= 1'b0;
      stamp_term_o <= 2'd0;
      stamp_vec_o  <= 16'h0000;
      stamp_time_o <= 32'h0000_0000;
    end else begin
      stamp_stb_o  <= |eow_fire;
      stamp_time_o <= ts_ff;
      if (eow_fire[0]) begin
        stamp_term_o <= 2'd0;
        stamp_vec_o  <= lbl_vec[15:0];
      end else if (eow_fire[1]) begin
        stamp_term_o <= 2'd1;
        stamp_vec_o  <= lbl_vec[31:16];
      end else if (eow_fire[2]) begin
        stamp_term_o <= 2'd2;
        stamp_vec_o  <= lbl_vec[47:32];
      end
    end
  end

  // =============================================
  // number parser and bus answer
  reg        force_ff;
  reg        force_hex_ff;
  reg        fresh_ff;
  reg [31:0] pval_ff;
  wire [7:0] ch    = wb_dat_i[7:0];
  wire       is_dg = (ch >= 8'h30) & (ch <= 8'h39);
  wire       is_lc = (ch >= 8'h61) & (ch <= 8'h66);
  wire       is_uc = (ch >= 8'h41) & (ch <= 8'h46);
  wire [3:0] dval  = is_dg ? ch[3:0] : (ch[3:0] + 4'h9);
  wire       hex_m = force_ff ? force_hex_ff : param_hex_ff;
  wire       dig   = is_dg | ((is_lc | is_uc) & hex_m);
  wire [31:0] base = fresh_ff ? 32'h0000_0000 : pval_ff;
  wire [31:0] accv = hex_m ? {base[27:0], dval} :
                     ({base[28:0], 3'b000} + {base[30:0], 1'b0} + {28'h000_0000, dval});

  always @(posedge clk_i) begin
    if (rst_i) begin
      force_ff <= 1'b0; force_hex_ff <= 1'b0; fresh_ff <= 1'b1;
      pval_ff  <= 32'h0000_0000;
    end else if (wr_chr) begin
      if (ch == `TTE_CHR_HASH) begin
        force_ff <= 1'b1; force_hex_ff <= 1'b1; fresh_ff <= 1'b1;
      end else if (ch == `TTE_CHR_PCT) begin
        force_ff <= 1'b1; force_hex_ff <= 1'b0; fresh_ff <= 1'b1;
      end else if (dig) begin
        pval_ff  <= accv;
        fresh_ff <= 1'b0;
      end else begin
        force_ff <= 1'b0; fresh_ff <= 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req & ~wb_we_i) begin
        if (wb_adr_i == `TTE_OFF_STATUS) begin
          wb_dat_o[`TTE_ST_DATA_HEX]          <= data_radix_hex_o;
          wb_dat_o[`TTE_ST_PARAM_HEX]         <= param_hex_ff;
          wb_dat_o[`TTE_ST_SYS_ERR_EN]        <= sys_err_en_ff;
          wb_dat_o[`TTE_ST_SYS_VEC_EN]        <= sys_vec_en_ff;
          wb_dat_o[`TTE_ST_TERM_LO +: 2]      <= cur_term_ff;
          wb_dat_o[`TTE_ST_CMD_ERR]           <= cmd_err_ff;
          wb_dat_o[`TTE_ST_THRESH_LO +: NT]   <= thresh_high_o;
          wb_dat_o[`TTE_ST_EOW_LO +: NT]      <= eow_en_ff;
          wb_dat_o[`TTE_ST_LOCK_LO +: NT]     <= lock_ff;
          wb_dat_o[`TTE_ST_TS_RUN]            <= ts_run_ff;
        end else if (wb_adr_i == `TTE_OFF_TS_PERIOD) begin
          wb_dat_o[14:0] <= period_ff;
        end else if (wb_adr_i == `TTE_OFF_TS_COUNT) begin
          wb_dat_o <= ts_ff;
        end else if (wb_adr_i == `TTE_OFF_PARSE_VAL) begin
          wb_dat_o <= pval_ff;
        end else if (wb_adr_i == `TTE_OFF_CMD) begin
          wb_dat_o[23:0] <= arm_ff[23:0];
        end
      end
    end
  end
endmodule // tte_top

// *** tte_top_assertions.sv ***
`timescale 1ns/1ps
// ==========
// port checks
module tte_top_assertions #(
  parameter NT       = 3,
  parameter TRIG_CYC = 4
) (
  input wire          clk_i,
  input wire          rst_i,
  input wire          wb_cyc_i,
  input wire          wb_stb_i,
  input wire          wb_ack_o,
  input wire [31:0]   wb_dat_o,
  input wire          vec_stb_i,
  input wire [NT-1:0] tx_start_i,
  input wire [NT-1:0] comm_err_i,
  input wire [NT-1:0] trig_ext_n_o,
  input wire          exec_stb_o,
  input wire [4:0]    exec_func_o,
  input wire          sys_vec_irq_o,
  input wire          sys_err_event_i,
  input wire          sys_err_irq_o,
  input wire [NT-1:0] rx_label_i,
  input wire [NT-1:0] early_vec_o,
  input wire [NT-1:0] late_vec_o,
  input wire [NT-1:0] ws_end_i,
  input wire          stamp_stb_o
);
  reg  [15:0] low_cnt_ff;
  wire        ws_any = |ws_end_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // low-time counter stands in for long repetitions
  always @(posedge clk_i) begin
    if (rst_i || trig_ext_n_o[0]) low_cnt_ff <= 16'h0000;
    else low_cnt_ff <= low_cnt_ff + 16'h0001;
  end
  a_ack_follows_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_trig_has_cause: assert property ($fell(trig_ext_n_o[0]) |->
    $past(vec_stb_i || tx_start_i[0] || comm_err_i[0] || wb_stb_i))
    else $error("trigger without cause");
  a_trig_not_short: assert property ($rose(trig_ext_n_o[0]) |-> low_cnt_ff == TRIG_CYC)
    else $error("trigger too short");
  a_trig_not_long: assert property (!trig_ext_n_o[0] |-> low_cnt_ff < TRIG_CYC)
    else $error("trigger too long");
  a_exec_after_vec: assert property (vec_stb_i |-> ##3 exec_stb_o)
    else $error("block not executed");
  a_sysvec_func: assert property (sys_vec_irq_o |-> exec_stb_o && exec_func_o == 5'h0f)
    else $error("vector irq not for f");
  a_syserr_cause: assert property (sys_err_irq_o |-> $past(sys_err_event_i))
    else $error("error irq without event");
  a_early_vec_time: assert property (rx_label_i[0] |-> ##151 early_vec_o[0])
    else $error("early vector missing");
  a_late_vec_time: assert property (rx_label_i[0] |-> ##176 late_vec_o[0])
    else $error("late vector missing");
  a_stamp_delay: assert property (stamp_stb_o |-> $past(ws_any, 126))
    else $error("stamp off its delay");
endmodule // tte_top_assertions

bind tte_top tte_top_assertions #(.NT(NT), .TRIG_CYC(TRIG_CYC)) i_chk (.*);

// *** tte_term_model.sv ***
`timescale 1ns/1ps
// ==========
// terminal side event source
module tte_term_model (
  input  wire        clk_i,
  output reg         vec_stb_o,
  output reg  [1:0]  vec_term_o,
  output reg  [15:0] vec_code_o,
  output reg  [2:0]  crc_fail_o,
  output reg  [47:0] rx_vec_o,
  output wire [12:0] ev_o
);
  reg [12:0] ev_ff;
  assign ev_o = ev_ff;
  initial begin
    {vec_stb_o, vec_term_o, vec_code_o, crc_fail_o, rx_vec_o, ev_ff} = 83'h0;
  end
  // released lines show the inverse so a late sample cannot pass by luck
  task vec(input [1:0] t, input [15:0] c);
    @(posedge clk_i);
    vec_stb_o <= 1'b1;
    vec_term_o <= t;
    vec_code_o <= c;
    @(posedge clk_i);
    vec_stb_o <= 1'b0;
    vec_term_o <= ~t;
    vec_code_o <= ~c;
  endtask
  task ev(input [3:0] k);
    @(posedge clk_i);
    ev_ff[k] <= 1'b1;
    @(posedge clk_i);
    ev_ff[k] <= 1'b0;
  endtask
  task crc(input [2:0] m);
    @(posedge clk_i);
    crc_fail_o <= m;
  endtask
  task lab(input [15:0] c);
    @(posedge clk_i);
    rx_vec_o[15:0] <= c;
    ev_ff[6] <= 1'b1;
    @(posedge clk_i);
    ev_ff[6] <= 1'b0;
  endtask
endmodule // tte_term_model

// *** tte_top_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tte_top_tb_top;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc_ff = 1'b0;
  reg         stb_ff = 1'b0;
  reg         we_ff = 1'b0;
  reg  [7:0]  adr_ff = 8'h00;
  reg  [31:0] wdat_ff = 32'h0000_0000;
  reg  [31:0] rd;
  int         num_errors = 0;
  int         compares = 0;
  int         cyc_cnt = 0;
  wire [31:0] dat_o;
  wire        ack, vstb, serr, mx_n, mb_n, svirq, seirq, stamp, hex_o;
  wire [1:0]  vterm, sterm;
  wire [15:0] vcode, svec;
  wire [2:0]  crc, tx_n, tbp_n, thr, st;
  wire [47:0] rxv;
  wire [12:0] ev, xq;
  wire [13:0] mon = {st, stamp, svirq, seirq, ~mb_n, ~mx_n, ~tbp_n, ~tx_n};
  tte_term_model i_term (.clk_i(clk_i), .vec_stb_o(vstb), .vec_term_o(vterm),
    .vec_code_o(vcode), .crc_fail_o(crc), .rx_vec_o(rxv), .ev_o(ev));
  tte_top #(.TRIG_CYC(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_ff),
    .wb_stb_i(stb_ff), .wb_we_i(we_ff), .wb_adr_i(adr_ff), .wb_sel_i(4'hf),
    .wb_dat_i(wdat_ff), .wb_dat_o(dat_o), .wb_ack_o(ack), .vec_stb_i(vstb),
    .vec_term_i(vterm), .vec_code_i(vcode), .crc_fail_i(crc), .tx_start_i(ev[2:0]),
    .comm_err_i(ev[5:3]), .sys_err_event_i(ev[12]), .rx_label_i(ev[8:6]), .rx_vec_i(rxv),
    .ws_end_i(ev[11:9]), .trig_ext_n_o(tx_n), .trig_bp_n_o(tbp_n), .mod_trig_ext_n_o(mx_n),
    .mod_trig_bp_n_o(mb_n), .thresh_high_o(thr), .self_test_o(st), .sys_err_irq_o(seirq),
    .sys_vec_irq_o(svirq), .exec_stb_o(), .exec_block_o(xq[7:0]), .exec_func_o(xq[12:8]),
    .early_vec_o(), .late_vec_o(), .stamp_stb_o(stamp), .stamp_term_o(sterm),
    .stamp_vec_o(svec), .stamp_time_o(), .data_radix_hex_o(hex_o));
  always #5 clk_i = ~clk_i;
  // ==========
  // bus and check tasks
  task bus(input w, input [7:0] a, input [31:0] d);
    @(posedge clk_i);
    cyc_ff <= 1'b1;
    stb_ff <= 1'b1;
    we_ff <= w;
    adr_ff <= a;
    wdat_ff <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_ff <= 1'b0;
    stb_ff <= 1'b0;
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK($sformatf("reg %h", a), e, rd & m)
  endtask
  task cmd(input [4:0] op, input [2:0] tg, input arg, input line);
    bus(1'b1, 8'h00, {22'h00_0000, line, arg, tg, op});
  endtask
  task pc(input [23:0] s);
    int k;
    for (k = 2; k >= 0; k--) bus(1'b1, 8'h10, {24'h00_0000, s[8*k+:8]});
  endtask
  // watch window covers the longest event delay
  task seen(input [3:0] i, input e);
    reg hit;
    hit = mon[i];
    repeat (140) begin
      @(negedge clk_i);
      hit = hit | mon[i];
    end
    `CHK($sformatf("mon %0d", i), e, hit)
  endtask
  task fire(input [1:0] kind, input [1:0] t);
    if (kind < 2) i_term.vec(t, 16'h2000);
    else i_term.ev(kind == 2 ? {2'b00, t} : 4'h3 + {2'b00, t});
  endtask
  task test_done;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      num_errors++;
      test_done;
    end
  end
  // ==========
  // scenarios
  initial begin
    int k;
    reg [1:0] t;
    reg [3:0] ix;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("idle", 14'h0000, mon)
    rdc(8'h00, 32'hffff_ffff, 32'h0000_0000);
    rdc(8'h14, 32'h0000_ffff, 32'h0000_0003);
    rdc(8'h20, 32'hffff_ffff, 32'h0000_0000);
    cmd(5'h04, 3'h0, 1'b0, 1'b0);
    `CHK("radix", 1'b0, hex_o)
    cmd(5'h05, 3'h0, 1'b0, 1'b0);
    rdc(8'h14, 32'h0000_0003, 32'h0000_0000);
    pc("#10");
    rdc(8'h1c, 32'hffff_ffff, 32'h0000_0010);
    pc(" %9");
    rdc(8'h1c, 32'hffff_ffff, 32'h0000_0009);
    pc(" 12");
    rdc(8'h1c, 32'hffff_ffff, 32'h0000_000c);
    cmd(5'h04, 3'h0, 1'b1, 1'b0);
    cmd(5'h05, 3'h0, 1'b1, 1'b0);
    rdc(8'h14, 32'h0000_0003, 32'h0000_0003);
    cmd(5'h08, 3'h6, 1'b1, 1'b0);
    cmd(5'h08, 3'h5, 1'b1, 1'b0);
    cmd(5'h08, 3'h0, 1'b0, 1'b0);
    `CHK("thresh", 3'h4, thr)
    cmd(5'h08, 3'h7, 1'b1, 1'b0);
    rdc(8'h14, 32'h0000_0040, 32'h0000_0040);
    `CHK("thresh", 3'h4, thr)
    for (k = 0; k < 4; k++) begin
      t = k % 3;
      ix = k[0] ? 4'h3 + {2'b00, t} : {2'b00, t};
      cmd(k[4:0], {1'b1, t}, 1'b1, k[0]);
      if (k == 0) i_term.vec(t, 16'h0005);
      if (k == 1) fire(2'h1, t);
      if (k < 2) seen(ix, 1'b0);
      if (k == 1) i_term.crc(3'h2);
      fire(k[1:0], t);
      seen(ix, 1'b1);
      cmd(k[4:0], {1'b1, t}, 1'b0, k[0]);
      fire(k[1:0], t);
      seen(ix, 1'b0);
      i_term.crc(3'h0);
    end
    cmd(5'h00, 3'h4, 1'b1, 1'b0);
    fire(2'h0, 2'h0);
    seen(4'h0, 1'b0);
    rdc(8'h14, 32'h0000_e000, 32'h0000_2000);
    cmd(5'h0f, 3'h4, 1'b0, 1'b0);
    fire(2'h0, 2'h0);
    seen(4'h0, 1'b1);
    for (k = 10; k < 14; k++) begin
      cmd(k[4:0], 3'h5, 1'b0, 1'b0);
      seen(16'h1467 >> (4 * (k - 10)) & 4'hf, 1'b1);
    end
    cmd(5'h0e, 3'h6, 1'b0, 1'b0);
    seen(4'hd, 1'b1);
    bus(1'b1, 8'h08, 32'h0007_0005);
    bus(1'b1, 8'h0c, 32'h0000_0f07);
    for (k = 3; k >= 0; k--) begin
      cmd(5'h06 + k[1], 3'h0, k[0], 1'b0);
      if (k[1]) i_term.vec(2'h1, 16'h0005);
      else i_term.ev(4'hc);
      seen(4'h8 + k[1], k[0]);
    end
    `CHK("exec", 13'h0f07, xq)
    cmd(5'h09, 3'h4, 1'b1, 1'b0);
    i_term.lab(16'h2003);
    i_term.ev(4'h9);
    seen(4'ha, 1'b1);
    `CHK("stamp", 18'h0_2003, {sterm, svec})
    cmd(5'h09, 3'h4, 1'b0, 1'b0);
    i_term.ev(4'h9);
    seen(4'ha, 1'b0);
    bus(1'b1, 8'h04, 32'h0000_0002);
    repeat (450) @(posedge clk_i);
    rdc(8'h18, 32'hffff_ffff, 32'h0000_0002);
    bus(1'b1, 8'h04, 32'h0000_0000);
    rdc(8'h04, 32'h0000_7fff, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_7fff);
    rdc(8'h04, 32'h0000_7fff, 32'h0000_7fff);
    test_done;
  end
endmodule // tte_top_tb_top
